/* File: shared/rflrc_pkg.sv */
package rflrc_pkg;

  // ---------------------------------------------------------------
  // Sample formats
  // ---------------------------------------------------------------
  localparam int SAMPLE_W = 16;  // Width of one I or Q component.
  localparam int COEF_W = 16;  // Width of correction coefficients (Q1.14).
  localparam int COEF_FRAC = 14;  // Fraction bits of coefficients.
  localparam int PHASE_W = 32;  // Width of the frequency shift accumulator.
  localparam int LUT_BITS = 6;  // Phase bits that address the sine table.
  localparam int FIFO_DEPTH = 32;  // Depth of each sample FIFO.

  // ---------------------------------------------------------------
  // Rates
  // ---------------------------------------------------------------
  localparam int LTE_RATE_KSPS = 30720;  // LTE sample rate, ksps.
  localparam int CONV_RATE_120_KHZ = 120000;  // Converter rate, variant A.
  localparam int CONV_RATE_200_KHZ = 200000;  // Converter rate, variant B.
  localparam int CONV_RATE_130_KHZ = 130000;  // Converter rate, variant C.
  localparam int RATIO_FRAC_W = 24;  // Fraction bits of rate ratio.
  // Ratio LTE/converter rate in 0.24 fixed point, one per variant.
  localparam logic [RATIO_FRAC_W:0] RATIO_120 =
    25'((64'(LTE_RATE_KSPS) << RATIO_FRAC_W) / CONV_RATE_120_KHZ);
  localparam logic [RATIO_FRAC_W:0] RATIO_200 =
    25'((64'(LTE_RATE_KSPS) << RATIO_FRAC_W) / CONV_RATE_200_KHZ);
  localparam logic [RATIO_FRAC_W:0] RATIO_130 =
    25'((64'(LTE_RATE_KSPS) << RATIO_FRAC_W) / CONV_RATE_130_KHZ);

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] VARIANT_RESET = 2'h0;  // Variant A after reset.
  localparam logic [3:0] DC_SHIFT_RESET = 4'h8;  // Default DC time constant.

  // Hardware variant selecting the converter rate.
  typedef enum logic [1:0] {
    RFLRC_RATE_120,
    RFLRC_RATE_200,
    RFLRC_RATE_130
  } rflrc_variant_type;

  // One complex baseband sample.
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } rflrc_iq_type;

  // I/Q imbalance correction: q' = q*gain + i*phase, i' = i.
  typedef struct packed {
    logic signed [COEF_W-1:0] gain;
    logic signed [COEF_W-1:0] phase;
  } rflrc_iqcal_type;

  // Tuning values supplied by the radio driver configuration.
  typedef struct packed {
    logic [1:0] variant;
    logic [PHASE_W-1:0] tx_freq_step;
    logic [PHASE_W-1:0] rx_freq_step;
    logic [3:0] dc_shift;
  } rflrc_cfg_type;

endpackage

/* File: design/rflrc_top.sv */
// ---------------------------------------------------------------
// Sample FIFO
// ---------------------------------------------------------------
// Sample FIFO with valid/ready on both sides; full blocks the writer.
module rflrc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Sample storage.
  logic [AW-1:0] wr_ptr;  // Next slot to write.
  logic [AW-1:0] rd_ptr;  // Next slot to read.
  logic [AW:0] count;  // Words held.
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Storage write; memory needs no reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end
endmodule

// Summary of operation
// - Interpolate LTE rate up to converter rate.
// - Shift transmit frequency by configured step.
// - Correct transmit I/Q imbalance with calibration.
// - Correct receive I/Q imbalance with calibration.
// - Fine frequency adjust received samples.
// - Decimate converter rate down to LTE rate.
// - Remove averaged DC estimate from receive.
// - Samples cross loops through on-chip FIFOs.
// - Everything runs on one clock.
module rflrc_top (
  input wire logic clk,
  input wire logic rst,
  input wire rflrc_pkg::rflrc_cfg_type cfg,
  input wire rflrc_pkg::rflrc_iqcal_type tx_cal,
  input wire rflrc_pkg::rflrc_iqcal_type rx_cal,
  input wire rflrc_pkg::rflrc_iq_type tx_in_data,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  input wire logic dac_strobe,
  output rflrc_pkg::rflrc_iq_type dac_data,
  output logic dac_valid,
  input wire rflrc_pkg::rflrc_iq_type adc_data,
  input wire logic adc_valid,
  output logic adc_ready,
  output rflrc_pkg::rflrc_iq_type rx_out_data,
  output logic rx_out_valid,
  input wire logic rx_out_ready
);
  import rflrc_pkg::*;

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  // Quarter-wave sine table mirrored out to one full 64-step period, Q1.14.
  function automatic logic signed [COEF_W-1:0] sine_lut(input logic [LUT_BITS-1:0] ph);
    logic signed [COEF_W-1:0] tab [16];
    logic [3:0] idx;
    logic signed [COEF_W-1:0] v;
    tab = '{16'sh0000, 16'sh0648, 16'sh0C7C, 16'sh1294, 16'sh187E, 16'sh1E2B,
            16'sh238E, 16'sh289A, 16'sh2D41, 16'sh3179, 16'sh3537, 16'sh3871,
            16'sh3B21, 16'sh3D3F, 16'sh3EC5, 16'sh3FB1};
    idx = ph[4] ? 4'(~ph[3:0] + 4'h1) : ph[3:0];
    v = (ph[4] && ph[3:0] == 4'h0) ? 16'sh4000 : tab[idx];
    sine_lut = ph[5] ? -v : v;
  endfunction

  // Saturate a wide signed value to one sample component.
  function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [SAMPLE_W+1:0] x);
    if (x > (SAMPLE_W+2)'(32767)) begin
      sat = 16'sh7FFF;
    end else if (x < -(SAMPLE_W+2)'(32768)) begin
      sat = 16'sh8000;
    end else begin
      sat = SAMPLE_W'(x);
    end
  endfunction

  // Imbalance correction: i kept, q rebuilt from gain and cross term.
  function automatic rflrc_iq_type iq_fix(input rflrc_iq_type s, input rflrc_iqcal_type c);
    logic signed [2*SAMPLE_W:0] acc;
    acc = (2*SAMPLE_W+1)'(s.q * c.gain) + (2*SAMPLE_W+1)'(s.i * c.phase);
    iq_fix.i = s.i;
    iq_fix.q = sat((SAMPLE_W+2)'(acc >>> COEF_FRAC));
  endfunction

  // Complex rotate by the phase accumulator's top bits.
  function automatic rflrc_iq_type rotate(input rflrc_iq_type s, input logic [LUT_BITS-1:0] ph);
    logic signed [COEF_W-1:0] sn;
    logic signed [COEF_W-1:0] cs;
    logic signed [2*SAMPLE_W:0] ri;
    logic signed [2*SAMPLE_W:0] rq;
    sn = sine_lut(ph);
    cs = sine_lut(LUT_BITS'(ph + LUT_BITS'(16)));
    ri = (2*SAMPLE_W+1)'(s.i * cs) - (2*SAMPLE_W+1)'(s.q * sn);
    rq = (2*SAMPLE_W+1)'(s.i * sn) + (2*SAMPLE_W+1)'(s.q * cs);
    rotate.i = sat((SAMPLE_W+2)'(ri >>> COEF_FRAC));
    rotate.q = sat((SAMPLE_W+2)'(rq >>> COEF_FRAC));
  endfunction

  // Rate ratio of the selected hardware variant.
  logic [RATIO_FRAC_W:0] ratio;
  always_comb begin
    unique case (rflrc_variant_type'(cfg.variant))
      RFLRC_RATE_200: ratio = RATIO_200;
      RFLRC_RATE_130: ratio = RATIO_130;
      default: ratio = RATIO_120;
    endcase
  end

  // ---------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------
  // Incoming LTE samples are buffered; the interpolator only pops one when
  // its phase wraps, so a stalled converter back-pressures the producer.
  rflrc_iq_type txf_data;
  logic txf_valid;
  logic txf_pop;
  rflrc_fifo #(.WIDTH($bits(rflrc_iq_type)), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(tx_in_data),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .out_data(txf_data),
    .out_valid(txf_valid),
    .out_ready(txf_pop)
  );

  logic [RATIO_FRAC_W:0] tx_mu;  // Fractional position between two inputs.
  rflrc_iq_type tx_prev;  // Older of the two interpolation points.
  rflrc_iq_type tx_cur;  // Newer interpolation point.
  logic tx_primed;  // Set once an input has been taken.
  logic [PHASE_W-1:0] tx_phase;  // Frequency shift accumulator.
  logic [RATIO_FRAC_W:0] next_tx_mu;
  assign next_tx_mu = (RATIO_FRAC_W+1)'(tx_mu + ratio);
  // Crossing 1.0 consumes a new input; on underrun the last value is held.
  assign txf_pop = dac_strobe && next_tx_mu[RATIO_FRAC_W];

  // Linear interpolation between tx_prev and tx_cur at position tx_mu.
  rflrc_iq_type tx_interp;
  always_comb begin
    logic signed [SAMPLE_W+RATIO_FRAC_W+1:0] di;
    logic signed [SAMPLE_W+RATIO_FRAC_W+1:0] dq;
    di = (SAMPLE_W+RATIO_FRAC_W+2)'((tx_cur.i - tx_prev.i) * $signed({1'b0, tx_mu}));
    dq = (SAMPLE_W+RATIO_FRAC_W+2)'((tx_cur.q - tx_prev.q) * $signed({1'b0, tx_mu}));
    tx_interp.i = sat((SAMPLE_W+2)'(tx_prev.i + (di >>> RATIO_FRAC_W)));
    tx_interp.q = sat((SAMPLE_W+2)'(tx_prev.q + (dq >>> RATIO_FRAC_W)));
  end

  // Interpolator state advances one step per converter strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_mu <= '0;
      tx_prev <= '0;
      tx_cur <= '0;
      tx_primed <= 1'b0;
    end else if (dac_strobe) begin
      tx_mu <= {1'b0, next_tx_mu[RATIO_FRAC_W-1:0]};
      if (txf_pop) begin
        tx_prev <= tx_cur;
        tx_cur <= txf_valid ? txf_data : tx_cur;
        tx_primed <= tx_primed | txf_valid;
      end
    end
  end

  // Shift then imbalance correction, registered toward the converter.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_phase <= '0;
      dac_data <= '0;
      dac_valid <= 1'b0;
    end else begin
      dac_valid <= dac_strobe && tx_primed;
      if (dac_strobe) begin
        tx_phase <= PHASE_W'(tx_phase + cfg.tx_freq_step);
        dac_data <= iq_fix(rotate(tx_interp, tx_phase[PHASE_W-1 -: LUT_BITS]), tx_cal);
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive path
  // ---------------------------------------------------------------
  logic rx_stage_ready;  // Decimator output can be accepted.
  assign adc_ready = rx_stage_ready;

  rflrc_iq_type rx_fixed;  // Imbalance-corrected, frequency-adjusted.
  logic rx_fixed_valid;
  logic [PHASE_W-1:0] rx_phase;  // Receive adjust accumulator.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_fixed <= '0;
      rx_fixed_valid <= 1'b0;
      rx_phase <= '0;
    end else begin
      rx_fixed_valid <= adc_valid && adc_ready;
      if (adc_valid && adc_ready) begin
        rx_phase <= PHASE_W'(rx_phase + cfg.rx_freq_step);
        rx_fixed <= rotate(iq_fix(adc_data, rx_cal), rx_phase[PHASE_W-1 -: LUT_BITS]);
      end
    end
  end

  // DC estimate: est += (x - est) >> shift, kept with 16 extra bits.
  logic signed [SAMPLE_W+15:0] dc_i;
  logic signed [SAMPLE_W+15:0] dc_q;
  rflrc_iq_type rx_clean;
  logic rx_clean_valid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dc_i <= '0;
      dc_q <= '0;
      rx_clean <= '0;
      rx_clean_valid <= 1'b0;
    end else begin
      rx_clean_valid <= rx_fixed_valid;
      if (rx_fixed_valid) begin
        dc_i <= (SAMPLE_W+16)'(dc_i
                 + (($signed({rx_fixed.i, 16'h0000}) - dc_i) >>> cfg.dc_shift));
        dc_q <= (SAMPLE_W+16)'(dc_q
                 + (($signed({rx_fixed.q, 16'h0000}) - dc_q) >>> cfg.dc_shift));
        rx_clean.i <= sat((SAMPLE_W+2)'(rx_fixed.i - (dc_i >>> 16)));
        rx_clean.q <= sat((SAMPLE_W+2)'(rx_fixed.q - (dc_q >>> 16)));
      end
    end
  end

  // Decimator: average of inputs spanning one output period, emitted
  // when the fractional phase wraps. Simple boxcar; trades stopband for area.
  logic [RATIO_FRAC_W:0] rx_mu;
  logic signed [SAMPLE_W+3:0] acc_i;
  logic signed [SAMPLE_W+3:0] acc_q;
  logic [2:0] acc_n;
  rflrc_iq_type dec_data;
  logic dec_valid;
  logic [RATIO_FRAC_W:0] next_rx_mu;
  assign next_rx_mu = (RATIO_FRAC_W+1)'(rx_mu + ratio);
  // Divide by the true input count; a fixed divisor would scale with the variant.
  localparam int RECIP_FRAC = 15;  // Fraction bits of the reciprocals.
  localparam logic [15:0] RECIP [8] = '{16'h8000, 16'h4000, 16'h2AAB, 16'h2000,
    16'h199A, 16'h1555, 16'h1249, 16'h1000};  // Reciprocal of acc_n plus one.
  logic signed [SAMPLE_W+20:0] avg_i;  // Period sum scaled by its reciprocal.
  logic signed [SAMPLE_W+20:0] avg_q;
  assign avg_i = (SAMPLE_W+21)'((acc_i + rx_clean.i) * $signed({1'b0, RECIP[acc_n]}));
  assign avg_q = (SAMPLE_W+21)'((acc_q + rx_clean.q) * $signed({1'b0, RECIP[acc_n]}));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_mu <= '0;
      acc_i <= '0;
      acc_q <= '0;
      acc_n <= '0;
      dec_data <= '0;
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= 1'b0;
      if (rx_clean_valid) begin
        rx_mu <= {1'b0, next_rx_mu[RATIO_FRAC_W-1:0]};
        if (next_rx_mu[RATIO_FRAC_W]) begin
          dec_valid <= 1'b1;
          dec_data <= '{i: SAMPLE_W'(avg_i >>> RECIP_FRAC),
                        q: SAMPLE_W'(avg_q >>> RECIP_FRAC)};
          acc_i <= '0;
          acc_q <= '0;
          acc_n <= '0;
        end else begin
          acc_i <= (SAMPLE_W+4)'(acc_i + rx_clean.i);
          acc_q <= (SAMPLE_W+4)'(acc_q + rx_clean.q);
          acc_n <= 3'(acc_n + 3'h1);
        end
      end
    end
  end

  // Output FIFO; its free space must cover samples already in the pipe,
  // so input is taken only while more than four slots remain.
  logic [5:0] rxf_level;
  logic rxf_in_ready;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxf_level <= '0;
    end else begin
      rxf_level <= 6'(rxf_level + (dec_valid ? 6'h01 : 6'h00)
                   - ((rx_out_valid && rx_out_ready) ? 6'h01 : 6'h00));
    end
  end
  assign rx_stage_ready = rxf_in_ready && (rxf_level < 6'(FIFO_DEPTH - 4));

  rflrc_fifo #(.WIDTH($bits(rflrc_iq_type)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(dec_data),
    .in_valid(dec_valid),
    .in_ready(rxf_in_ready),
    .out_data(rx_out_data),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready)
  );
endmodule

/* File: sim/rflrc_properties.sv */
module rflrc_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_in_valid,
  input wire logic tx_in_ready,
  input wire logic dac_strobe,
  input wire rflrc_pkg::rflrc_iq_type dac_data,
  input wire logic dac_valid,
  input wire logic adc_valid,
  input wire logic adc_ready,
  input wire rflrc_pkg::rflrc_iq_type rx_out_data,
  input wire logic rx_out_valid,
  input wire logic rx_out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import rflrc_pkg::*;

  // -------------------------------------------------------------
  // Helper counters
  // -------------------------------------------------------------
  logic no_pop;  // No strobe since reset, so the transmit FIFO can only grow.
  logic [5:0] fill;  // Words taken since reset; read only while no_pop holds.
  logic [5:0] idle;  // Cycles with the sink ready and no converter input.

  // Clears on the first strobe, since a pop makes the level unknown here.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      no_pop <= 1'b1;
    end else if (dac_strobe) begin
      no_pop <= 1'b0;
    end
  end

  // Counts accepted words, saturating so it cannot wrap to empty.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill <= 6'h00;
    end else if (tx_in_valid && tx_in_ready && fill != 6'h3F) begin
      fill <= fill + 6'h01;
    end
  end

  // Long enough to cover four pipeline stages plus a full FIFO drain.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle <= 6'h00;
    end else if (!rx_out_ready || adc_valid) begin
      idle <= 6'h00;
    end else if (idle != 6'h3F) begin
      idle <= idle + 6'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  AST_DAC_AFTER_STROBE: assert property (dac_valid |-> $past(dac_strobe))
    else $error("dac_valid without a strobe one cycle before");
  AST_DAC_HOLD: assert property (!dac_strobe |=> $stable(dac_data))
    else $error("dac_data moved without a strobe");
  AST_RX_HOLD: assert property (rx_out_valid && !rx_out_ready |=>
    rx_out_valid && $stable(rx_out_data))
    else $error("receive output dropped or changed while stalled");
  AST_RX_DRAINS: assert property (idle == 6'h3F |-> !rx_out_valid)
    else $error("receive output appears with no input");
  AST_TX_ROOM: assert property (no_pop && fill < 6'(FIFO_DEPTH) |-> tx_in_ready)
    else $error("transmit FIFO refused before full");
  AST_TX_FULL: assert property (no_pop && fill == 6'(FIFO_DEPTH) |-> !tx_in_ready)
    else $error("transmit FIFO took more than its depth");
  AST_RX_ROOM: assert property (!rx_out_valid |-> adc_ready)
    else $error("converter input refused with an empty output FIFO");
  AST_TX_STAYS_FULL: assert property (!tx_in_ready && !dac_strobe |=> !tx_in_ready)
    else $error("transmit FIFO freed space without a strobe");

  cover property (no_pop && fill == 6'(FIFO_DEPTH));
  cover property (rx_out_valid && !rx_out_ready);
  cover property (dac_valid && !adc_ready);
endmodule

bind rflrc_top rflrc_properties chk (
  .clk(clk),
  .rst(rst),
  .tx_in_valid(tx_in_valid),
  .tx_in_ready(tx_in_ready),
  .dac_strobe(dac_strobe),
  .dac_data(dac_data),
  .dac_valid(dac_valid),
  .adc_valid(adc_valid),
  .adc_ready(adc_ready),
  .rx_out_data(rx_out_data),
  .rx_out_valid(rx_out_valid),
  .rx_out_ready(rx_out_ready)
);

/* File: sim/rflrc_loop_model.sv */
module rflrc_loop_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic src_en,
  input wire rflrc_pkg::rflrc_iq_type src_val,
  input wire logic stall,
  input wire logic tx_in_ready,
  output rflrc_pkg::rflrc_iq_type tx_in_data,
  output logic tx_in_valid,
  input wire rflrc_pkg::rflrc_iq_type rx_out_data,
  input wire logic rx_out_valid,
  output logic rx_out_ready,
  output int push_cnt,
  output int pop_cnt,
  output rflrc_pkg::rflrc_iq_type last_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  import rflrc_pkg::*;

  // -------------------------------------------------------------
  // Transmitter loop: offers samples, holds each until taken
  // -------------------------------------------------------------
  // Idle data is inverted so a stale word never looks valid.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_in_valid <= 1'b0;
      tx_in_data <= ~src_val;
    end else if (!tx_in_valid || tx_in_ready) begin
      tx_in_valid <= src_en;
      tx_in_data <= src_en ? src_val : ~src_val;
    end
  end

  // -------------------------------------------------------------
  // Receiver loop: drains samples, may stall at will
  // -------------------------------------------------------------
  always @(posedge clk) begin
    rx_out_ready <= !stall && !rst;
    if (!rst && tx_in_valid && tx_in_ready) begin
      push_cnt <= push_cnt + 1;
    end
    if (!rst && rx_out_valid && rx_out_ready) begin
      pop_cnt <= pop_cnt + 1;
      last_rx <= rx_out_data;
    end
  end
endmodule

/* File: sim/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rflrc_pkg::*;

  // One row: variant and transmit correction with the q it should give.
  typedef struct {
    logic [1:0] variant;
    logic [15:0] gain;
    logic [15:0] phase;
    logic signed [15:0] exp_q;
    int conv;
  } rflrc_row_type;

  localparam rflrc_iq_type SMP = '{16'sh1000, 16'sh0800};
  rflrc_row_type rows [3] = '{
    '{2'h0, 16'h4000, 16'h0000, 16'sh0800, CONV_RATE_120_KHZ},
    '{2'h1, 16'h4000, 16'h2000, 16'sh1000, CONV_RATE_200_KHZ},
    '{2'h2, 16'h2000, 16'h0000, 16'sh0400, CONV_RATE_130_KHZ}};
  logic clk, rst, tx_in_valid, tx_in_ready, dac_strobe, dac_valid;
  logic adc_valid, adc_ready, rx_out_valid, rx_out_ready;
  logic src_en, stall, adc_on, strobe_on;
  rflrc_cfg_type cfg;
  rflrc_iqcal_type tx_cal, rx_cal;
  rflrc_iq_type tx_in_data, dac_data, adc_data, rx_out_data, last_rx;
  int push_cnt, pop_cnt, dac_cnt, err_total, num_checks;

  rflrc_top uut (.clk(clk), .rst(rst), .cfg(cfg), .tx_cal(tx_cal), .rx_cal(rx_cal),
    .tx_in_data(tx_in_data), .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
    .dac_strobe(dac_strobe), .dac_data(dac_data), .dac_valid(dac_valid),
    .adc_data(adc_data), .adc_valid(adc_valid), .adc_ready(adc_ready),
    .rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready));
  rflrc_loop_model lm (.clk(clk), .rst(rst), .src_en(src_en), .src_val(SMP),
    .stall(stall), .tx_in_ready(tx_in_ready), .tx_in_data(tx_in_data),
    .tx_in_valid(tx_in_valid), .rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid),
    .rx_out_ready(rx_out_ready), .push_cnt(push_cnt), .pop_cnt(pop_cnt), .last_rx(last_rx));

  // -------------------------------------------------------------
  // Clock and converter side
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The converter holds a pending sample until it is taken.
  always @(posedge clk) begin
    dac_strobe <= strobe_on;
    if (!adc_valid || adc_ready) begin
      adc_valid <= adc_on;
      adc_data <= adc_on ? SMP : ~SMP;
    end
    if (dac_valid) begin
      dac_cnt <= dac_cnt + 1;
    end
  end

  // -------------------------------------------------------------
  // Compare tasks and closing report
  // -------------------------------------------------------------
  task automatic chk_bit(string name, logic ex, logic got);
    num_checks++;
    if (got !== ex) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", name, ex, got);
    end
  endtask

  task automatic chk_rng(string name, int lo, int hi, int got);
    num_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // Filters round, so a few steps of slack are allowed.
  task automatic chk_val(string name, logic signed [15:0] ex, logic signed [15:0] got);
    logic ok;
    ok = (got >= ex - 16'sh0004) && (got <= ex + 16'sh0004);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, ex, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    int p0, r0, v0, ex, n;
    rst = 1'b1;
    cfg = '{VARIANT_RESET, 32'h0000_0000, 32'h0000_0000, 4'h2};
    tx_cal = '{16'sh4000, 16'sh0000};
    rx_cal = '{16'sh4000, 16'sh0000};
    {src_en, stall, adc_on, strobe_on} = 4'h0;
    dac_cnt = 0;
    do_reset();
    // Steady streaming per variant: rates, transmit correction, DC removal.
    for (int r = 0; r < 3; r++) begin
      cfg.variant <= rows[r].variant;
      tx_cal <= '{rows[r].gain, rows[r].phase};
      rx_cal <= '{rows[r].gain, rows[r].phase};
      do_reset();
      {src_en, adc_on, strobe_on} <= 3'h7;
      repeat (200) @(posedge clk);
      #1;
      p0 = push_cnt;
      r0 = pop_cnt;
      v0 = dac_cnt;
      repeat (1000) @(posedge clk);
      #1;
      ex = 1000 * LTE_RATE_KSPS / rows[r].conv;
      chk_rng("tx_pull", ex - 3, ex + 3, push_cnt - p0);
      chk_rng("rx_rate", ex - 3, ex + 3, pop_cnt - r0);
      chk_rng("dac_pace", 999, 1001, dac_cnt - v0);
      chk_val("dac_i", 16'sh1000, dac_data.i);
      chk_val("dac_q", rows[r].exp_q, dac_data.q);
      chk_val("rx_q", 16'sh0000, last_rx.q);
      chk_val("rx_i", 16'sh0000, last_rx.i);
      $display("variant row %0d done", r);
    end
    // Reset levels, then strobes with nothing queued give no output.
    {src_en, adc_on, strobe_on} <= 3'h0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_bit("tx_in_ready", 1'b1, tx_in_ready);
    chk_bit("adc_ready", 1'b1, adc_ready);
    chk_bit("dac_valid", 1'b0, dac_valid);
    chk_bit("rx_out_valid", 1'b0, rx_out_valid);
    cfg.dc_shift <= 4'hF;
    do_reset();
    v0 = dac_cnt;
    strobe_on <= 1'b1;
    repeat (8) @(posedge clk);
    strobe_on <= 1'b0;
    @(posedge clk);
    #1;
    chk_rng("underrun", 0, 0, dac_cnt - v0);
    $display("reset test done");
    // A slow DC estimate leaves the corrected level nearly whole at first.
    adc_on <= 1'b1;
    repeat (12) @(posedge clk);
    adc_on <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    chk_val("rx_cal_q", rows[2].exp_q, last_rx.q);
    chk_val("rx_cal_i", SMP.i, last_rx.i);
    $display("receive correction test done");
    do_reset();
    // Fill the transmit FIFO with no strobes until it refuses.
    p0 = push_cnt;
    src_en <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (tx_in_ready && n < 100);
    if (n >= 100) begin
      err_total++;
      wrap_up();
    end
    repeat (4) @(posedge clk);
    #1;
    chk_rng("tx_fill", FIFO_DEPTH, FIFO_DEPTH, push_cnt - p0);
    $display("transmit fill test done");
    // Stall the receiver until the converter is refused, then drain.
    {stall, strobe_on} <= 2'h3;
    adc_on <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (adc_ready && n < 400);
    if (n >= 400) begin
      err_total++;
      wrap_up();
    end
    repeat (8) @(posedge clk);
    #1;
    chk_bit("adc_refused", 1'b0, adc_ready);
    r0 = pop_cnt;
    {adc_on, stall} <= 2'h0;
    repeat (80) @(posedge clk);
    #1;
    chk_rng("rx_drain", FIFO_DEPTH - 4, FIFO_DEPTH, pop_cnt - r0);
    chk_bit("rx_empty", 1'b0, rx_out_valid);
    $display("receive stall test done");
    wrap_up();
  end
endmodule
